// ==== hw/asi_top.sv ====
// Serial status flags, control enables and shared interrupt, Avalon-MM
//
// Behaviour
// - Wait mode runs on; enabled requests wake
// - Halt freezes registers and suspends the link
// - One vector; enable set and mask clear
// - Transmit-empty bit 7 set on holding move
// - Status access then data write clears transmit
// - Transmit-done bit 6 only after data frames
// - Receive-ready bit 5 set on word transfer
// - Status access then data read clears receive
// - Quiet-line bit 4, rearmed by receive-ready
// - Overrun bit 3 when word meets ready flag
// - Overrun keeps holding word, drops new one
// - Noise bit 2, no own interrupt
// - Framing bit 1, no own interrupt
// - Framing plus overrun sets only overrun
// - Parity bit 0, interrupt, sequence clears it
// - Status read-only, resets to c0
// - Transmit enables at control two bits 7,6
// - Parity enable at control one bit 0
`timescale 1ns/1ns
`default_nettype none
module asi_top #(
   parameter int DATA_W = 8
) (
   input wire logic SYS_CLK,
   input wire logic RESET_N,
   input wire logic [3:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   input wire logic TX_LOAD_PULSE,
   input wire logic TX_FRAME_END,
   input wire logic TX_FRAME_DATA,
   input wire logic RX_WORD_END,
   input wire logic [DATA_W-1:0] RX_WORD,
   input wire logic RX_NOISE,
   input wire logic RX_FRAMING,
   input wire logic RX_PARITY_BAD,
   input wire logic RX_LINE_IDLE,
   input wire logic WAIT_MODE,
   input wire logic HALT_MODE,
   input wire logic CPU_IRQ_MASK,
   output logic [DATA_W-1:0] TX_HOLD,
   output logic TX_HOLD_FULL,
   output logic LINK_FREEZE,
   output logic IRQ_REQ,
   output logic WAIT_WAKE
);
   asi_flag_if fi ();

   asi_pkg::asi_bus_st_t st_q, st_d;
   logic wait_q, wait_d;
   logic [31:0] rdata_q, rdata_d;
   logic [7:0] ctrl1_q, ctrl1_d;
   logic [7:0] ctrl2_q, ctrl2_d;
   logic [DATA_W-1:0] rx_hold_q, rx_hold_d;
   logic [DATA_W-1:0] tx_hold_q, tx_hold_d;
   logic tx_full_q, tx_full_d;
   logic freeze_q, freeze_d;
   logic irq_q, irq_d;
   logic wake_q, wake_d;
   logic req, accept, sel_stat, sel_data, sel_c1, sel_c2;
   logic pending;

   asi_flags u_flags (
      .clk(SYS_CLK),
      .rst_n(RESET_N),
      .fi(fi)
   );

   // Address decode; an access completes on the edge wait is low
   assign req = AVS_READ || AVS_WRITE;
   assign accept = req && (st_q == asi_pkg::BUS_ACK);
   assign sel_stat = (AVS_ADDRESS == asi_pkg::OFS_STATUS);
   assign sel_data = (AVS_ADDRESS == asi_pkg::OFS_DATA);
   assign sel_c1 = (AVS_ADDRESS == asi_pkg::OFS_CTRL1);
   assign sel_c2 = (AVS_ADDRESS == asi_pkg::OFS_CTRL2);

   // Events and access strobes toward the flag unit
   assign fi.halt = HALT_MODE;
   assign fi.tx_load = TX_LOAD_PULSE;
   assign fi.tx_done = TX_FRAME_END;
   assign fi.tx_is_data = TX_FRAME_DATA;
   assign fi.rx_done = RX_WORD_END;
   assign fi.rx_noise = RX_NOISE;
   assign fi.rx_framing = RX_FRAMING;
   assign fi.rx_parity = RX_PARITY_BAD;
   assign fi.rx_idle = RX_LINE_IDLE;
   assign fi.stat_acc = accept && sel_stat;
   assign fi.data_rd = accept && AVS_READ && sel_data;
   assign fi.data_wr = accept && AVS_WRITE && sel_data
      && AVS_BYTEENABLE[0];

   // Bus handshake: one wait cycle, none taken while halted
   always_comb begin
      st_d = st_q;
      wait_d = 1'b1;
      case (st_q)
         asi_pkg::BUS_IDLE: begin
            if (req && !HALT_MODE) begin
               st_d = asi_pkg::BUS_ACK;
               wait_d = 1'b0;
            end
         end
         asi_pkg::BUS_ACK: begin
            st_d = asi_pkg::BUS_IDLE;
         end
         default: begin
            st_d = asi_pkg::BUS_IDLE;
         end
      endcase
   end

   // Bus state registers
   always_ff @(posedge SYS_CLK) begin
      if (!RESET_N) begin
         st_q <= asi_pkg::BUS_IDLE;
         wait_q <= 1'b1;
      end else begin
         st_q <= st_d;
         wait_q <= wait_d;
      end
   end

   // Read data is captured as the wait cycle ends and stands one cycle
   always_comb begin
      rdata_d = 32'h0000_0000;
      if (st_q == asi_pkg::BUS_IDLE && AVS_READ && !HALT_MODE) begin
         if (sel_stat) begin
            rdata_d[7:0] = fi.flags;
         end else if (sel_data) begin
            rdata_d[DATA_W-1:0] = rx_hold_q;
         end else if (sel_c1) begin
            rdata_d[7:0] = ctrl1_q;
         end else if (sel_c2) begin
            rdata_d[7:0] = ctrl2_q;
         end
      end
   end

   // Read data register
   always_ff @(posedge SYS_CLK) begin
      if (!RESET_N) begin
         rdata_q <= 32'h0000_0000;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // Control, holding and data registers; status writes are ignored
   always_comb begin
      ctrl1_d = ctrl1_q;
      ctrl2_d = ctrl2_q;
      tx_hold_d = tx_hold_q;
      tx_full_d = tx_full_q;
      rx_hold_d = rx_hold_q;
      if (accept && AVS_WRITE && AVS_BYTEENABLE[0]) begin
         if (sel_c1) begin
            ctrl1_d = AVS_WRITEDATA[7:0];
         end
         if (sel_c2) begin
            ctrl2_d = AVS_WRITEDATA[7:0];
         end
         if (sel_data) begin
            tx_hold_d = AVS_WRITEDATA[DATA_W-1:0];
            tx_full_d = 1'b1;
         end
      end
      // Shifter took the word, holding register is free again
      if (TX_LOAD_PULSE) begin
         tx_full_d = 1'b0;
      end
      // A word is taken only while receive-ready is clear
      if (fi.rx_take) begin
         rx_hold_d = RX_WORD;
      end
      if (HALT_MODE) begin
         ctrl1_d = ctrl1_q;
         ctrl2_d = ctrl2_q;
         tx_hold_d = tx_hold_q;
         tx_full_d = tx_full_q;
         rx_hold_d = rx_hold_q;
      end
   end

   // Register storage
   always_ff @(posedge SYS_CLK) begin
      if (!RESET_N) begin
         ctrl1_q <= asi_pkg::CTRL1_RST;
         ctrl2_q <= asi_pkg::CTRL2_RST;
         tx_hold_q <= DATA_W'(asi_pkg::DATA_RST);
         tx_full_q <= 1'b0;
         rx_hold_q <= DATA_W'(asi_pkg::DATA_RST);
      end else begin
         ctrl1_q <= ctrl1_d;
         ctrl2_q <= ctrl2_d;
         tx_hold_q <= tx_hold_d;
         tx_full_q <= tx_full_d;
         rx_hold_q <= rx_hold_d;
      end
   end

   // Shared request: noise and framing have no enable of their own
   assign pending =
      (fi.flags[asi_pkg::BIT_TX_EMPTY] && ctrl2_q[asi_pkg::BIT_TX_EMPTY_IE])
      || (fi.flags[asi_pkg::BIT_TX_DONE]
         && ctrl2_q[asi_pkg::BIT_TX_DONE_IE])
      || ((fi.flags[asi_pkg::BIT_RX_READY]
         || fi.flags[asi_pkg::BIT_OVERRUN])
         && ctrl2_q[asi_pkg::BIT_RX_READY_IE])
      || (fi.flags[asi_pkg::BIT_QUIET] && ctrl2_q[asi_pkg::BIT_QUIET_IE])
      || (fi.flags[asi_pkg::BIT_PARITY]
         && ctrl1_q[asi_pkg::BIT_PARITY_IE]);

   // Interrupt, wake and freeze outputs; halt never wakes the device
   always_comb begin
      irq_d = pending && !CPU_IRQ_MASK;
      wake_d = pending && WAIT_MODE && !HALT_MODE;
      freeze_d = HALT_MODE;
      if (HALT_MODE) begin
         irq_d = irq_q; // Frozen with the rest of the block
      end
   end

   // Output registers
   always_ff @(posedge SYS_CLK) begin
      if (!RESET_N) begin
         irq_q <= 1'b0;
         wake_q <= 1'b0;
         freeze_q <= 1'b0;
      end else begin
         irq_q <= irq_d;
         wake_q <= wake_d;
         freeze_q <= freeze_d;
      end
   end

   assign AVS_READDATA = rdata_q;
   assign AVS_WAITREQUEST = wait_q;
   assign TX_HOLD = tx_hold_q;
   assign TX_HOLD_FULL = tx_full_q;
   assign LINK_FREEZE = freeze_q;
   assign IRQ_REQ = irq_q;
   assign WAIT_WAKE = wake_q;
endmodule // asi_top
`default_nettype wire

// ==== hw/asi_pkg.sv ====
// Constants for the serial status, flag and interrupt block
package asi_pkg;
   // Register byte offsets on the Avalon-MM slave
   localparam logic [3:0] OFS_STATUS = 4'h0;
   localparam logic [3:0] OFS_DATA = 4'h4;
   localparam logic [3:0] OFS_CTRL1 = 4'h8;
   localparam logic [3:0] OFS_CTRL2 = 4'hc;
   // Status bit positions
   localparam int BIT_TX_EMPTY = 7;
   localparam int BIT_TX_DONE = 6;
   localparam int BIT_RX_READY = 5;
   localparam int BIT_QUIET = 4;
   localparam int BIT_OVERRUN = 3;
   localparam int BIT_NOISE = 2;
   localparam int BIT_FRAMING = 1;
   localparam int BIT_PARITY = 0;
   // Enable bit positions in the control registers
   localparam int BIT_PARITY_IE = 0;
   localparam int BIT_TX_EMPTY_IE = 7;
   localparam int BIT_TX_DONE_IE = 6;
   localparam int BIT_RX_READY_IE = 5;
   localparam int BIT_QUIET_IE = 4;
   // Reset values
   localparam logic [7:0] STATUS_RST = 8'hc0;
   localparam logic [7:0] CTRL1_RST = 8'h00;
   localparam logic [7:0] CTRL2_RST = 8'h00;
   localparam logic [7:0] DATA_RST = 8'h00;
   localparam logic QUIET_ARM_RST = 1'b1;
   // Bus handshake states
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_ACK = 2'b10
   } asi_bus_st_t;
endpackage

// ==== hw/asi_flag_if.sv ====
// Link between the register front end and the status flag unit
`timescale 1ns/1ns
`default_nettype none
interface asi_flag_if;
   logic halt;
   logic tx_load;
   logic tx_done;
   logic tx_is_data;
   logic rx_done;
   logic rx_noise;
   logic rx_framing;
   logic rx_parity;
   logic rx_idle;
   logic stat_acc;
   logic data_rd;
   logic data_wr;
   logic rx_take;
   logic [7:0] flags;
   modport front (output halt, tx_load, tx_done, tx_is_data, rx_done,
      rx_noise, rx_framing, rx_parity, rx_idle, stat_acc, data_rd,
      data_wr, input rx_take, flags);
   modport unit (input halt, tx_load, tx_done, tx_is_data, rx_done,
      rx_noise, rx_framing, rx_parity, rx_idle, stat_acc, data_rd,
      data_wr, output rx_take, flags);
endinterface
`default_nettype wire

// ==== hw/asi_flags.sv ====
// Status flag unit: set events and the read-then-access clear sequence
`timescale 1ns/1ns
`default_nettype none
module asi_flags (
   input wire logic clk,
   input wire logic rst_n,
   asi_flag_if.unit fi
);
   logic [7:0] flag_q, flag_d;
   logic [7:0] snap_q, snap_d;
   logic arm_q, arm_d;
   logic take;

   // Word moves to the data register only when the last one was read
   assign take = fi.rx_done && !flag_q[asi_pkg::BIT_RX_READY];
   assign fi.rx_take = take && !fi.halt;
   assign fi.flags = flag_q;

   // Next flag values; clear first, then sets so a same-cycle event wins
   always_comb begin
      logic [7:0] clr;
      clr = 8'h00;
      flag_d = flag_q;
      snap_d = snap_q;
      arm_d = arm_q;
      if (fi.stat_acc) begin
         snap_d = flag_q; // Only flags seen by software may be cleared
      end
      if (fi.data_wr) begin
         clr[asi_pkg::BIT_TX_EMPTY] = snap_q[asi_pkg::BIT_TX_EMPTY];
         clr[asi_pkg::BIT_TX_DONE] = snap_q[asi_pkg::BIT_TX_DONE];
         // Parity clears on any data access, a write as well
         clr[asi_pkg::BIT_PARITY] = snap_q[asi_pkg::BIT_PARITY];
      end
      if (fi.data_rd) begin
         clr[5:0] = snap_q[5:0];
      end
      if (fi.data_wr || fi.data_rd) begin
         snap_d = 8'h00;
      end
      flag_d = flag_q & ~clr;
      if (fi.tx_load) begin
         flag_d[asi_pkg::BIT_TX_EMPTY] = 1'b1;
      end
      if (fi.tx_done && fi.tx_is_data) begin
         flag_d[asi_pkg::BIT_TX_DONE] = 1'b1;
      end
      if (fi.rx_done && !take) begin
         flag_d[asi_pkg::BIT_OVERRUN] = 1'b1;
      end
      if (take) begin
         flag_d[asi_pkg::BIT_RX_READY] = 1'b1;
         arm_d = 1'b1;
         if (fi.rx_noise) begin
            flag_d[asi_pkg::BIT_NOISE] = 1'b1;
         end
         if (fi.rx_framing) begin
            flag_d[asi_pkg::BIT_FRAMING] = 1'b1;
         end
         if (fi.rx_parity) begin
            flag_d[asi_pkg::BIT_PARITY] = 1'b1;
         end
      end
      if (fi.rx_idle && arm_q) begin
         flag_d[asi_pkg::BIT_QUIET] = 1'b1;
         arm_d = 1'b0;
      end
      // Halt freezes every flag and the sequence state
      if (fi.halt) begin
         flag_d = flag_q;
         snap_d = snap_q;
         arm_d = arm_q;
      end
   end

   // Flag registers
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         flag_q <= asi_pkg::STATUS_RST;
         snap_q <= 8'h00;
         arm_q <= asi_pkg::QUIET_ARM_RST;
      end else begin
         flag_q <= flag_d;
         snap_q <= snap_d;
         arm_q <= arm_d;
      end
   end
endmodule // asi_flags
`default_nettype wire

// ==== sim/asi_properties.sv ====
// Port checker: bus timing, holding register, halt, mask and wake
`timescale 1ns/1ns
`default_nettype none
module asi_properties #(
   parameter int DATA_W = 8
) (
   input wire logic SYS_CLK,
   input wire logic RESET_N,
   input wire logic [3:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   input wire logic [31:0] AVS_READDATA,
   input wire logic AVS_WAITREQUEST,
   input wire logic TX_LOAD_PULSE,
   input wire logic WAIT_MODE,
   input wire logic HALT_MODE,
   input wire logic CPU_IRQ_MASK,
   input wire logic [DATA_W-1:0] TX_HOLD,
   input wire logic TX_HOLD_FULL,
   input wire logic IRQ_REQ,
   input wire logic WAIT_WAKE
);
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RESET_N);
   // Request seen while the slave rests
   sequence s_req_taken;
      (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST && !HALT_MODE;
   endsequence
   // Data write completing at this edge
   sequence s_data_wr;
      AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0]
         && AVS_ADDRESS == asi_pkg::OFS_DATA;
   endsequence
   a_bus_answer: assert property (
      s_req_taken |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
      else $error("bus answer not after one wait cycle");
   a_rdata_rest: assert property (
      AVS_READDATA[31:8] == 24'h0
         && (!AVS_WAITREQUEST || AVS_READDATA == 32'h0))
      else $error("read data outside its cycle");
   a_hold_written: assert property (
      s_data_wr |=> TX_HOLD_FULL
         && TX_HOLD == $past(AVS_WRITEDATA[DATA_W-1:0]))
      else $error("holding register not written");
   a_load_empties: assert property (
      TX_LOAD_PULSE && AVS_WAITREQUEST && !HALT_MODE |=> !TX_HOLD_FULL)
      else $error("holding register still full after load");
   a_mask_blocks: assert property (
      $past(CPU_IRQ_MASK) && !$past(HALT_MODE) && !$past(HALT_MODE, 2)
         |-> !IRQ_REQ)
      else $error("request while masked");
   a_halt_frozen: assert property (
      $past(HALT_MODE) && $past(HALT_MODE, 2) |-> $stable(IRQ_REQ)
         && $stable(TX_HOLD) && $stable(TX_HOLD_FULL))
      else $error("state moved during halt");
   a_wake_gated: assert property (
      !WAIT_MODE || HALT_MODE |=> !WAIT_WAKE)
      else $error("wake outside wait");
   a_wake_irq: assert property (
      $past(WAIT_MODE) && !$past(HALT_MODE) && !$past(CPU_IRQ_MASK)
         && !$past(HALT_MODE, 2) |-> WAIT_WAKE == IRQ_REQ)
      else $error("wake differs from unmasked request");
endmodule // asi_properties
bind asi_top asi_properties #(.DATA_W(DATA_W)) u_props (
   .SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .AVS_ADDRESS(AVS_ADDRESS),
   .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
   .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
   .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
   .TX_LOAD_PULSE(TX_LOAD_PULSE), .WAIT_MODE(WAIT_MODE),
   .HALT_MODE(HALT_MODE), .CPU_IRQ_MASK(CPU_IRQ_MASK), .TX_HOLD(TX_HOLD),
   .TX_HOLD_FULL(TX_HOLD_FULL), .IRQ_REQ(IRQ_REQ), .WAIT_WAKE(WAIT_WAKE)
);
`default_nettype wire

// ==== sim/asi_line_model.sv ====
// Far-end transceiver model: line-side event strobes
`timescale 1ns/1ns
`default_nettype none
module asi_line_model (
   input wire logic clk,
   output logic tx_load,
   output logic tx_end,
   output logic tx_data,
   output logic rx_end,
   output logic [7:0] rx_word,
   output logic [2:0] rx_err,
   output logic rx_idle
);
   // Quiet line at start
   initial begin
      {tx_load, tx_end, tx_data, rx_end, rx_idle} = 5'h00;
      rx_word = 8'h00;
      rx_err = 3'h0;
   end
   // Word with quality bits; scrambled once released
   task automatic rx(input logic [7:0] w, input logic [2:0] e);
      @(posedge clk);
      rx_end <= 1'b1;
      rx_word <= w;
      rx_err <= e;
      @(posedge clk);
      rx_end <= 1'b0;
      rx_word <= ~w;
      rx_err <= ~e;
   endtask
   // One-cycle strobe: 0 holding moved, 1 idle line
   task automatic pulse(input logic k);
      @(posedge clk);
      if (k) rx_idle <= 1'b1;
      else tx_load <= 1'b1;
      @(posedge clk);
      rx_idle <= 1'b0;
      tx_load <= 1'b0;
   endtask
   // Frame end; 0 marks a break or preamble
   task automatic frame(input logic d);
      @(posedge clk);
      tx_end <= 1'b1;
      tx_data <= d;
      @(posedge clk);
      tx_end <= 1'b0;
      tx_data <= ~d;
   endtask
endmodule // asi_line_model
`default_nettype wire

// ==== sim/test_asi_top.sv ====
// Bench: register accesses and flag sequences
`timescale 1ns/1ns
`default_nettype none
module test_asi_top;
   localparam logic [3:0] ST = asi_pkg::OFS_STATUS;
   localparam logic [3:0] DR = asi_pkg::OFS_DATA;
   localparam logic [3:0] C1 = asi_pkg::OFS_CTRL1;
   localparam logic [3:0] C2 = asi_pkg::OFS_CTRL2;
   logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0;
   logic waitm = 1'b0, halt = 1'b0, mask = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [3:0] be = 4'hf;
   logic [31:0] wdata = 32'h0, rdata;
   logic [7:0] hold, rw;
   logic [2:0] rerr;
   logic wreq, full, irq, wake, tl, te, td, re, ri, frz;
   int error_cnt = 0, total_checks = 0, cyc = 0;
   initial forever #4 clk = ~clk;
   asi_top #(.DATA_W(8)) dut (
      .SYS_CLK(clk), .RESET_N(rst_n), .AVS_ADDRESS(addr), .AVS_READ(rd),
      .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be),
      .AVS_READDATA(rdata), .AVS_WAITREQUEST(wreq), .TX_LOAD_PULSE(tl),
      .TX_FRAME_END(te), .TX_FRAME_DATA(td), .RX_WORD_END(re),
      .RX_WORD(rw), .RX_NOISE(rerr[2]), .RX_FRAMING(rerr[1]),
      .RX_PARITY_BAD(rerr[0]), .RX_LINE_IDLE(ri), .WAIT_MODE(waitm),
      .HALT_MODE(halt), .CPU_IRQ_MASK(mask), .TX_HOLD(hold),
      .TX_HOLD_FULL(full), .LINK_FREEZE(frz), .IRQ_REQ(irq),
      .WAIT_WAKE(wake)
   );
   asi_line_model lm (
      .clk(clk), .tx_load(tl), .tx_end(te), .tx_data(td), .rx_end(re),
      .rx_word(rw), .rx_err(rerr), .rx_idle(ri)
   );
   task automatic report_and_stop;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // Four-state compare so an unknown never matches
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Request held until waitrequest is seen low
   task automatic bus(input logic w, input logic [3:0] a,
      input logic [7:0] d, output logic [31:0] q);
      addr <= a;
      rd <= !w;
      wr <= w;
      wdata <= {d, d, d, d}; // Upper lanes must be ignored
      do @(posedge clk); while (wreq !== 1'b0);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wrr(input logic [3:0] a, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rdc(input logic [3:0] a, input logic [7:0] e);
      logic [31:0] q;
      bus(1'b0, a, 8'h00, q);
      chk(q, {24'h0, e});
   endtask
   // Request and wake lag their cause by registered stages
   task automatic lines(input logic i, input logic k);
      repeat (2) @(posedge clk);
      chk({30'h0, irq, wake}, {30'h0, i, k});
   endtask
   // Hang guard, far above the fewer than two hundred cycles needed
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         error_cnt++;
         report_and_stop;
      end
   end
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rdc(ST, 8'hc0);
      wrr(ST, 8'h00);
      rdc(ST, 8'hc0);
      rdc(4'h2, 8'h00);
      wrr(C2, 8'h80);
      rdc(C2, 8'h80);
      be <= 4'he;
      wrr(C2, 8'h7f);
      be <= 4'hf;
      rdc(C2, 8'h80);
      lines(1'b1, 1'b0);
      mask <= 1'b1;
      lines(1'b0, 1'b0);
      mask <= 1'b0;
      rdc(ST, 8'hc0);
      wrr(DR, 8'h5a);
      rdc(ST, 8'h00);
      chk({23'h0, full, hold}, 32'h15a);
      lines(1'b0, 1'b0);
      lm.pulse(1'b0);
      rdc(ST, 8'h80);
      chk({31'h0, full}, 32'h0);
      wrr(C2, 8'h40);
      lm.frame(1'b0);
      rdc(ST, 8'h80);
      lines(1'b0, 1'b0);
      lm.frame(1'b1);
      rdc(ST, 8'hc0);
      lines(1'b1, 1'b0);
      wrr(C2, 8'h20);
      lm.rx(8'h11, 3'b100);
      rdc(ST, 8'he4);
      lines(1'b1, 1'b0);
      lm.pulse(1'b1);
      rdc(ST, 8'hf4);
      lm.rx(8'h22, 3'b010);
      rdc(ST, 8'hfc);
      rdc(DR, 8'h11);
      rdc(ST, 8'hc0);
      lines(1'b0, 1'b0);
      lm.pulse(1'b1);
      rdc(ST, 8'hc0);
      wrr(C1, 8'h01);
      lm.rx(8'h33, 3'b001);
      rdc(ST, 8'he1);
      wrr(C2, 8'h00);
      lines(1'b1, 1'b0);
      rdc(DR, 8'h33);
      rdc(ST, 8'hc0);
      lines(1'b0, 1'b0);
      lm.rx(8'h44, 3'b001);
      rdc(DR, 8'h44);
      rdc(ST, 8'he1);
      wrr(DR, 8'h3c);
      rdc(ST, 8'h20);
      rdc(DR, 8'h44);
      rdc(ST, 8'h00);
      lm.pulse(1'b0);
      halt <= 1'b1;
      lm.rx(8'h55, 3'b000);
      lm.pulse(1'b1);
      chk({31'h0, frz}, 32'h1);
      halt <= 1'b0;
      rdc(ST, 8'h80);
      chk({31'h0, frz}, 32'h0);
      wrr(C2, 8'h80);
      waitm <= 1'b1;
      lines(1'b1, 1'b1);
      mask <= 1'b1;
      lines(1'b0, 1'b1);
      halt <= 1'b1;
      lines(1'b0, 1'b0);
      report_and_stop;
   end
endmodule // test_asi_top
`default_nettype wire
